// ==== sram_boundary_scan_tap.sv ====
// Purpose: test access port with opcode, shortcut, identity and pin ring chains
// Assumes: tck from the external scan controller, core_clk for the memory side
// Notes:   the forced-off request crosses into core_clk through two flops
//
// Notes on behaviour
// R1: state advances on tck rise using tms
// R2: opcode 000 captures ring, outputs off
// R3: opcode 001 loads and shifts identity word
// R4: opcode 010 captures ring, drivers off
// R5: opcode 100 captures ring, memory untouched
// R6: opcode 111 selects one-bit shortcut register
// R7: controller never loads the reserved opcodes; here update-ir loads any code and reserved ones select the shortcut bit
// R8: identity holds revision, device, vendor fields
// R9: identity bit zero always reads one
// R10: output on falling edge, input on rising
// R11: five high tms edges reset the port
// R12: reset preloads the identity opcode
// R13: opcode capture loads 01 in low bits
// R14: standard sixteen state port controller
`timescale 1ns/1ps

module sram_boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int          CHAIN_LEN = RING_LEN,   // pin ring chain length
  parameter logic [2:0]  REV_CODE  = 3'h5,       // arbitrary value
  parameter logic [16:0] DEV_CODE  = 17'h0a5a5,  // arbitrary value
  parameter logic [10:0] VEN_CODE  = 11'h155     // arbitrary value
)(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  input  wire logic [CHAIN_LEN-1:0] pin_ring,
  output      serial_out_t          serial_out,
  output      logic                 mem_outputs_off
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check: the shift logic needs at least two chain bits
  if (CHAIN_LEN < 2)
  begin : g_len_check
    $error("chain length must be at least two");
  end

  localparam logic [ID_LEN-1:0] ID_WORD = {REV_CODE, DEV_CODE, VEN_CODE, ID_PRESENT};

  ////////////////////////////////////////////////////////////////////////
  // functions
  // next controller state from the present state and tms
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    tap_state_t n;
    n = st_reset;
    case (s)
      st_reset:    n = m ? st_reset    : st_idle;
      st_idle:     n = m ? st_sel_dr   : st_idle;
      st_sel_dr:   n = m ? st_sel_ir   : st_cap_dr;
      st_cap_dr:   n = m ? st_exit1_dr : st_shift_dr;
      st_shift_dr: n = m ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: n = m ? st_upd_dr   : st_pause_dr;
      st_pause_dr: n = m ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: n = m ? st_upd_dr   : st_shift_dr;
      st_upd_dr:   n = m ? st_sel_dr   : st_idle;
      st_sel_ir:   n = m ? st_reset    : st_cap_ir;
      st_cap_ir:   n = m ? st_exit1_ir : st_shift_ir;
      st_shift_ir: n = m ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: n = m ? st_upd_ir   : st_pause_ir;
      st_pause_ir: n = m ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: n = m ? st_upd_ir   : st_shift_ir;
      st_upd_ir:   n = m ? st_sel_dr   : st_idle;
      default:     n = st_reset;
    endcase
    return n;
  endfunction

  // which data chain an opcode places between the test pins
  // reserved codes fall back to the shortcut bit, the shortest safe path
  function automatic dr_sel_t dr_select(input logic [2:0] op);
    dr_sel_t d;
    d = sel_shortcut;
    case (op)
      OP_IDENT:      d = sel_ident;
      OP_RING_OFF,
      OP_SAMPLE_OFF,
      OP_SAMPLE:     d = sel_ring;
      default:       d = sel_shortcut;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // tck domain reset: asserts at once, releases on tck
  logic tap_rst_meta;  // first stage, read only by the second
  logic tap_rst_n;     // released reset for the link side

  always_ff @(posedge tck or negedge nrst)
  begin
    if (!nrst)
    begin
      tap_rst_meta <= 1'b0;
      tap_rst_n    <= 1'b0;
    end
    else
    begin
      tap_rst_meta <= 1'b1;
      tap_rst_n    <= tap_rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // controller state
  tap_state_t state;  // present controller state
  dr_sel_t    sel;    // chain chosen by the active opcode

  // a five-high tms run lands in reset from any state
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      state <= st_reset;
    else
      state <= tap_next(state, tms);  // [R1] [R11] [R14]
  end

  ////////////////////////////////////////////////////////////////////////
  // opcode shift register and active opcode
  logic [IR_LEN-1:0] ir_shift;  // opcode shift stage
  logic [IR_LEN-1:0] ir;        // active opcode

  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      ir_shift <= IR_RESET;
    else if (state == st_cap_ir)
      ir_shift <= {IR_CAPTURE_MSB, IR_CAPTURE_PAT};  // [R13]
    else if (state == st_shift_ir)
      ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};  // [R10]
  end

  // the active opcode only changes at update or in the reset state, so shifting never disturbs it
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      ir <= IR_RESET;  // [R12]
    else if (state == st_reset)
      ir <= IR_RESET;  // [R12]
    else if (state == st_upd_ir)
      ir <= ir_shift;  // [R14]
  end

  assign sel = dr_select(ir);  // [R2] [R3] [R4] [R5] [R6]

  ////////////////////////////////////////////////////////////////////////
  // pin ring sampling: pins are asynchronous to tck
  logic [CHAIN_LEN-1:0] ring_meta;  // first stage, read only by the second
  logic [CHAIN_LEN-1:0] ring_sync;  // settled pin ring

  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ring_meta <= '0;
      ring_sync <= '0;
    end
    else
    begin
      ring_meta <= pin_ring;
      ring_sync <= ring_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data chains; update-dr has no effect since there is no preload
  logic                 shortcut;  // one-bit bypass path
  logic [ID_LEN-1:0]    id_shift;  // identity word chain
  logic [CHAIN_LEN-1:0] ring;      // pin ring chain

  // shortcut bit
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      shortcut <= SHORTCUT_CAP;
    else if (state == st_cap_dr && sel == sel_shortcut)
      shortcut <= SHORTCUT_CAP;  // [R6]
    else if (state == st_shift_dr && sel == sel_shortcut)
      shortcut <= tdi;  // [R10]
  end

  // identity chain, fixed word loaded at capture
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      id_shift <= '0;
    else if (state == st_cap_dr && sel == sel_ident)
      id_shift <= ID_WORD;  // [R3] [R8] [R9]
    else if (state == st_shift_dr && sel == sel_ident)
      id_shift <= {tdi, id_shift[ID_LEN-1:1]};  // [R10]
  end

  // pin ring chain; a pin moving near capture may give either value
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      ring <= '0;
    else if (state == st_cap_dr && sel == sel_ring)
      ring <= ring_sync;  // [R2] [R4] [R5]
    else if (state == st_shift_dr && sel == sel_ring)
      ring <= {tdi, ring[CHAIN_LEN-1:1]};  // [R10]
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output on the falling edge, driven only while shifting
  always_ff @(negedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      serial_out.data   <= 1'b0;
      serial_out.enable <= 1'b0;  // [R11]
    end
    else
    begin
      serial_out.enable <= (state == st_shift_ir) || (state == st_shift_dr);  // [R10]
      if (state == st_shift_ir)
        serial_out.data <= ir_shift[0];
      else if (sel == sel_ident)
        serial_out.data <= id_shift[0];  // [R3]
      else if (sel == sel_ring)
        serial_out.data <= ring[0];  // [R2] [R4] [R5]
      else
        serial_out.data <= shortcut;  // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs-off request, decided on tck
  logic outputs_off_req;  // high for the two forcing opcodes

  // set at the same edge as the opcode, so a controller that stops tck
  // right after update-ir still gets the memory outputs forced off
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      outputs_off_req <= 1'b0;
    else if (state == st_reset)
      outputs_off_req <= 1'b0;  // [R12]
    else if (state == st_upd_ir)
      outputs_off_req <= (ir_shift == OP_RING_OFF) || (ir_shift == OP_SAMPLE_OFF);  // [R2] [R4]
  end

  ////////////////////////////////////////////////////////////////////////
  // level crossing into core_clk; sample and shortcut leave memory alone
  logic off_meta;  // first stage, read only by the second

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      off_meta        <= 1'b0;
      mem_outputs_off <= 1'b0;
    end
    else
    begin
      off_meta        <= outputs_off_req;
      mem_outputs_off <= off_meta;  // [R2] [R4] [R5] [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks in the tck domain
  sequence tms_held_five;
    tms [*5];
  endsequence

  sequence ident_capture;
    state == st_cap_dr && sel == sel_ident;
  endsequence

  sequence ring_capture;
    state == st_cap_dr && sel == sel_ring;
  endsequence

  a_tms_five_reset: assert property (  // [R11]
    @(posedge tck) disable iff (!tap_rst_n)
    tms_held_five |=> state == st_reset)
    else $error("five high tms edges did not reset the port");

  a_reset_preload: assert property (  // [R12]
    @(posedge tck) disable iff (!tap_rst_n)
    state == st_reset |=> ir == OP_IDENT)
    else $error("identity opcode not preloaded");

  a_ir_capture_pat: assert property (  // [R13]
    @(posedge tck) disable iff (!tap_rst_n)
    state == st_cap_ir |=> ir_shift[1:0] == 2'h1)
    else $error("opcode capture pattern wrong");

  a_ident_word: assert property (  // [R3]
    @(posedge tck) disable iff (!tap_rst_n)
    ident_capture |=> id_shift[0] == 1'b1 && id_shift[31:29] == REV_CODE
                      && id_shift[11:1] == VEN_CODE && id_shift[28:12] == DEV_CODE)
    else $error("identity word not loaded");

  a_ring_capture: assert property (  // [R5]
    @(posedge tck) disable iff (!tap_rst_n)
    ring_capture |=> ring == $past(ring_sync))
    else $error("pin ring not captured");

  a_shortcut_path: assert property (  // [R6]
    @(posedge tck) disable iff (!tap_rst_n)
    state == st_shift_dr && ir == OP_SHORTCUT |=> shortcut == $past(tdi))
    else $error("shortcut bit did not take tdi");

  a_update_opcode: assert property (  // [R14]
    @(posedge tck) disable iff (!tap_rst_n)
    state == st_upd_ir |=> ir == $past(ir_shift))
    else $error("opcode not updated");

  a_off_request: assert property (  // [R4]
    @(posedge tck) disable iff (!tap_rst_n)
    (ir == OP_SAMPLE_OFF || ir == OP_RING_OFF) ##1 $stable(ir) |-> outputs_off_req)
    else $error("outputs-off request missing");

  a_tdo_enable: assert property (  // [R10]
    @(negedge tck) disable iff (!tap_rst_n)
    $rose(serial_out.enable) |-> $past(state == st_shift_ir || state == st_shift_dr))
    else $error("serial output driven outside shift");

endmodule

// ==== tap_pkg.sv ====
// Purpose: shared constants and types of the scan test port
// Assumes: three-bit opcode, 32-bit identity word, 69-bit pin ring chain
// Notes:   identity field values live as module parameters, not here
package tap_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int IR_LEN      = 3;   // opcode register length
  localparam int ID_LEN      = 32;  // identity word length
  localparam int RING_LEN    = 69;  // pin ring chain length
  localparam int ID_REV_LSB  = 29;  // revision field 31:29
  localparam int ID_DEV_LSB  = 12;  // device field 28:12
  localparam int ID_VEN_LSB  = 1;   // vendor field 11:1

  ////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [2:0] OP_RING_OFF    = 3'h0; // capture ring, outputs off
  localparam logic [2:0] OP_IDENT       = 3'h1; // identity word
  localparam logic [2:0] OP_SAMPLE_OFF  = 3'h2; // sample, drivers off
  localparam logic [2:0] OP_SAMPLE      = 3'h4; // sample, memory untouched
  localparam logic [2:0] OP_SHORTCUT    = 3'h7; // single bit path

  ////////////////////////////////////////////////////////////////////////
  // reset and capture values
  localparam logic [2:0] IR_RESET       = OP_IDENT; // preload after reset
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;     // board path check
  localparam logic       IR_CAPTURE_MSB = 1'h0;     // upper capture bit
  localparam logic       ID_PRESENT     = 1'h1;     // bit 0 of identity
  localparam logic       SHORTCUT_CAP   = 1'h0;     // shortcut capture value

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_t;

  typedef enum logic [1:0] {
    sel_shortcut, sel_ident, sel_ring
  } dr_sel_t;

  typedef struct packed {
    logic data;    // serial test output level
    logic enable;  // high while the pin is driven
  } serial_out_t;

endpackage

// ==== scan_ctl_model.sv ====
// Purpose: behavioural scan controller that walks the test port from outside
// Assumes: tck stands still between calls; one tick is a 6 ns tck period
// Notes:   tdo is taken 1 ns after the fall, once it has settled, and 2 ns before the next rise
`timescale 1ns/1ps

module scan_ctl_model
  import tap_pkg::*;
(
  output logic        tck,
  output logic        tms,
  output logic        tdi,
  input  serial_out_t serial_out
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels: clock low and still, mode high keeps the port in reset
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one tck period: sample tdo, set mode and data while low, then pulse
  task automatic tick(input logic m, input logic d, output logic q, output logic e);
    #1;
    q = serial_out.data;   // settled since the last fall
    e = serial_out.enable;
    tms = m;               // branch level seen at the rise
    tdi = d;               // shifted in on the rise
    #2 tck = 1'b1;
    #3 tck = 1'b0;
  endtask

  // walk n mode levels, lsb first, ignoring tdo
  task automatic walk(input logic [7:0] pat, input int n);
    logic q;
    logic e;
    for (int i = 0; i < n; i++)
      tick(pat[i], 1'b0, q, e);
  endtask

  // five high mode edges, then idle; reset is the only way out
  task automatic port_reset();
    walk(8'h1f, 5);
    walk(8'h00, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // from idle: one scan of n bits through the ir or a data chain, back to idle
  // only the caller chooses opcodes; reserved ones are never sent
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout, output logic en_all);
    logic q;
    logic e;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);  // standard path to shift
    en_all = 1'b1;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], q, e);      // leave shift on the last bit
      dout[i] = q;
      en_all = en_all & e;
    end
    walk(8'h01, 2);                        // update, then idle
  endtask
endmodule

// ==== sram_boundary_scan_tap_tb.sv ====
// Purpose: self-checking bench of the scan test port
// Assumes: pin ring held steady so every capture sees the same levels
// Notes:   tck only runs inside the controller's calls
`timescale 1ns/1ps

module sram_boundary_scan_tap_tb;
  import tap_pkg::*;

  localparam logic [2:0]   REV = 3'h5;                       // arbitrary value
  localparam logic [16:0]  DEV = 17'h0a5a5;                  // arbitrary value
  localparam logic [10:0]  VEN = 11'h155;                    // arbitrary value
  localparam logic [31:0]  ID_EXP = {REV, DEV, VEN, 1'b1};   // expected identity
  localparam logic [68:0]  RING = 69'h1a_5a5a_5a5a_0f0f_3c3c; // pin levels

  logic               core_clk;  // memory clock
  logic               nrst;      // active low reset
  logic               tck;       // test clock
  logic               tms;       // mode select
  logic               tdi;       // serial in
  logic [68:0]        pin_ring;  // pin ring levels
  serial_out_t        serial_out; // tdo and its enable
  logic               mem_outputs_off; // forced high impedance
  int                 bad_count;
  int                 checked;
  logic [127:0]       dout;      // bits seen on tdo
  logic               en;        // enable high on every shifted bit

  ////////////////////////////////////////////////////////////////////////
  // clocks and parts
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  sram_boundary_scan_tap #(.REV_CODE(REV), .DEV_CODE(DEV), .VEN_CODE(VEN)) u_dut (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .tck             (tck),
    .tms             (tms),
    .tdi             (tdi),
    .pin_ring        (pin_ring),
    .serial_out      (serial_out),
    .mem_outputs_off (mem_outputs_off)
  );

  scan_ctl_model u_ctl (
    .tck        (tck),
    .tms        (tms),
    .tdi        (tdi),
    .serial_out (serial_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // opcode load; the capture pattern comes out first
  task automatic load_ir(input logic [2:0] op);
    u_ctl.scan(1'b1, 3, 128'(op), dout, en);
    check(dout[2:0], 3'h1);
    check(en, 1'b1);
  endtask

  // let the forced-off request cross into the memory clock
  task automatic settle_off(input logic exp);
    repeat (5) @(posedge core_clk);
    #1;
    check(mem_outputs_off, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_ident();
    u_ctl.scan(1'b0, 32, '0, dout, en);
    check(dout[31:0], ID_EXP);
    #1;
    check(serial_out.enable, 1'b0);
  endtask

  // ring opcodes back to back, outputs off only for the first two
  task automatic t_ring();
    logic [2:0] ops[3];
    logic       off[3];
    ops = '{OP_RING_OFF, OP_SAMPLE_OFF, OP_SAMPLE};
    off = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++)
    begin
      load_ir(ops[i]);
      settle_off(off[i]);
      u_ctl.scan(1'b0, 69, '0, dout, en);
      check(dout[68:0], RING);
      settle_off(off[i]);
    end
  endtask

  // shortcut delays the data by exactly one bit, capture bit first
  task automatic t_shortcut();
    load_ir(OP_SHORTCUT);
    u_ctl.scan(1'b0, 8, 128'h00a5, dout, en);
    check(dout[7:0], {7'h25, SHORTCUT_CAP});
    settle_off(1'b0);
  endtask

  // mode-high reset brings back the identity opcode without nrst
  task automatic t_tms_reset();
    load_ir(OP_RING_OFF);
    settle_off(1'b1);
    u_ctl.port_reset();
    settle_off(1'b0);
    t_ident();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence; a stuck run is cut short by the watchdog
  initial
  begin
    bad_count = 0;
    checked = 0;
    nrst = 1'b0;
    pin_ring = RING;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    u_ctl.port_reset();
    #1;
    check(serial_out.enable, 1'b0);
    t_ident();
    t_ring();
    t_shortcut();
    t_tms_reset();
    finish_test();
  end

  initial
  begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule
